// File: hfd_pkg.sv
// constants and types for the haptic frame decoder
// Operation
// (RULE1) Top bit of each frame byte: 0 marks first byte, 1 marks second byte.
// (RULE2) First-byte gain code gives 0, 6, 12 or 18 dB attenuation.
// (RULE3) Normal timebase codes map to 5.44, 21.76, 43.52, 87.04 ms.
// (RULE4) Fast timebase codes map to 1.36, 5.44, 21.76, 43.52 ms.
// (RULE5) Low three snippet index bits come from the first byte.
// (RULE6) Second-byte repeat field plus one gives the number of passes.
// (RULE7) Without a second byte the snippet plays exactly once.
// (RULE8) Passes after the first restart from the first stored point.
// (RULE9) Frequency-present bit set makes a three-byte frame with low frequency bits.
// (RULE10) Nine-bit frequency code spans 1 to 1024 Hz in 2 Hz steps; the decoder computes 2 * code + 2, giving 2 to 1024 Hz.
// (RULE11) Decoded drive frequency below 25 Hz is raised to 25 Hz.
// (RULE12) Drive frequency is converted to a period and shown for readback.
// (RULE13) Snippet index high bit comes from second byte, else zero.
// (RULE14) Without tracking, a commanded frequency holds until another one arrives.
// (RULE15) Controller sends frequency frames only while resonance tracking is off.
// (RULE16) A first byte with its type flag set raises a memory fault.
// (RULE17) Snippet index zero is a built-in silent point of two timebases.
// (RULE18) Frame bytes are fetched in ascending order; flags decide frame length.
package hfd_pkg;

  // ==========================================================
  // frame byte layout
  localparam int TYPE_BIT = 7;
  localparam int GAIN_MSB = 6;
  localparam int GAIN_LSB = 5;
  localparam int TB_MSB = 4;
  localparam int TB_LSB = 3;
  localparam int IDX_LOW_MSB = 2;
  localparam int REP_MSB = 6;
  localparam int REP_LSB = 3;
  localparam int DRIVE_FREQUENCY_CODE_PRESENT_BIT = 2;
  localparam int DRIVE_FREQUENCY_CODE_MSB_BIT = 1;
  localparam int IDX_HIGH_BIT = 0;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TB_UNIT_NS = 1360000;
  localparam int TB_UNIT_CYCLES = (TB_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] TB_MULT_1 = 7'h01;
  localparam logic [6:0] TB_MULT_4 = 7'h04;
  localparam logic [6:0] TB_MULT_16 = 7'h10;
  localparam logic [6:0] TB_MULT_32 = 7'h20;
  localparam logic [6:0] TB_MULT_64 = 7'h40;
  localparam logic [2:0] SILENT_TIMEBASES = 3'h2;

  // ==========================================================
  // gain and frequency
  localparam logic [4:0] ATTEN_STEP_DB = 5'h06;
  localparam logic [10:0] DRIVE_FREQUENCY_CODE_MIN_HZ = 11'h019;
  localparam logic [10:0] DRIVE_FREQUENCY_CODE_STEP_OFFSET_HZ = 11'h002;
  localparam logic [19:0] PERIOD_NUM_US = 20'hf4240;
  localparam logic [8:0] DRIVE_FREQUENCY_CODE_CODE_RESET = 9'h000;
  localparam logic [15:0] PERIOD_RESET = 16'h0000;

  typedef enum logic [2:0] {
    HFD_IDLE,
    HFD_READ,
    HFD_WAIT,
    HFD_PASS
  } hfd_state_t;

endpackage

// File: hfd_period_div.sv
// serial divider turning drive frequency into period in microseconds
`timescale 1ns/10ps
`default_nettype none
module hfd_period_div
  import hfd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [10:0] drive_frequency_code_hz,
  output logic busy,
  output logic done,
  output logic [15:0] period
);

  logic [19:0] quot;
  logic [10:0] divisor;
  logic [11:0] rem;
  logic [4:0] count;
  wire [11:0] shifted = {rem[10:0], quot[19]};
  wire sub_ok = shifted >= {1'b0, divisor};
  wire [11:0] next_rem = sub_ok ? shifted - {1'b0, divisor} : shifted;
  wire [19:0] next_quot = {quot[18:0], sub_ok};

  // ==========================================================
  // one quotient bit per cycle, twenty cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      quot <= 20'h00000;
      rem <= 12'h000;
      divisor <= 11'h001;
      count <= 5'h00;
      period <= PERIOD_RESET;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        quot <= PERIOD_NUM_US;
        rem <= 12'h000;
        divisor <= drive_frequency_code_hz;
        count <= 5'h14;
      end else if (busy) begin
        quot <= next_quot;
        rem <= next_rem;
        count <= count - 5'h01;
        if (count == 5'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
          period <= next_quot[15:0]; // see (RULE12)
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: hfd_frame_decoder.sv
// frame command decoder between waveform memory and playback engine
`timescale 1ns/10ps
`default_nettype none
module hfd_frame_decoder
  import hfd_pkg::*;
#(
  parameter int ADDR_W = 7,
  parameter int TB_CYCLES = TB_UNIT_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  // sequence control
  input wire logic seq_start,
  input wire logic [ADDR_W-1:0] seq_first_addr,
  input wire logic [ADDR_W-1:0] seq_last_addr,
  input wire logic fast_timebase_sel,
  input wire logic resonance_tracking_enable,
  output logic seq_busy,
  output logic seq_done,
  output logic mem_fault,
  // waveform memory
  output logic mem_rd_en,
  output logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_rd_valid,
  input wire logic [7:0] mem_rd_data,
  // playback engine, one command per pass
  output logic pass_valid,
  input wire logic pass_ready,
  output logic [3:0] snippet_index,
  output logic silent_snippet,
  output logic [2:0] silent_timebases,
  output logic [1:0] gain_code,
  output logic [4:0] atten_db,
  output logic [1:0] timebase_code,
  output logic [21:0] timebase_cycles,
  output logic [3:0] repeat_count,
  output logic [3:0] pass_number,
  output logic restart_from_first,
  output logic last_pass,
  // drive frequency
  output logic [8:0] drive_frequency_code,
  output logic drive_frequency_code_commanded,
  output logic drive_frequency_code_hold,
  output logic drive_frequency_code_update,
  output logic [15:0] active_period_readback,
  output logic period_busy
);

  // ==========================================================
  // reset release
  logic rst_meta;
  logic rst_sync_n;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ==========================================================
  // frame byte fields
  hfd_state_t state;
  hfd_state_t next_state;
  logic [1:0] stage;
  logic [7:0] byte1;
  logic [7:0] byte2;
  logic have_byte2;

  wire byte_is_second = mem_rd_data[TYPE_BIT]; // see (RULE1)
  wire first_bad = (stage == 2'h0) && byte_is_second; // see (RULE16)
  wire at_last = (mem_addr == seq_last_addr);
  wire second_ok = (stage == 2'h1) && byte_is_second;
  wire want_third = second_ok && mem_rd_data[DRIVE_FREQUENCY_CODE_PRESENT_BIT]; // see (RULE9)
  wire commit_now = mem_rd_valid && (state == HFD_WAIT) && (
    (stage == 2'h0 && !byte_is_second && at_last) ||
    (stage == 2'h1 && !byte_is_second) ||
    (second_ok && (!want_third || at_last)) ||
    (stage == 2'h2)); // see (RULE18)
  wire consume = !(stage == 2'h1 && !byte_is_second);
  wire seq_end_after = at_last || !consume ? at_last : 1'b0;

  wire [3:0] dec_repeat = have_byte2 ? byte2[REP_MSB:REP_LSB] : 4'h0; // see (RULE6) (RULE7)
  wire dec_idx_high = have_byte2 ? byte2[IDX_HIGH_BIT] : 1'b0; // see (RULE13)
  wire [3:0] dec_index = {dec_idx_high, byte1[IDX_LOW_MSB:0]}; // see (RULE5)
  wire [1:0] dec_tb = byte1[TB_MSB:TB_LSB];
  wire [1:0] dec_gain = byte1[GAIN_MSB:GAIN_LSB];

  // rebuild the latched fields from the byte just read, where it finishes the frame
  wire [7:0] fin_b1 = (stage == 2'h0) ? mem_rd_data : byte1;
  wire fin_has2 = (stage == 2'h1) ? second_ok : have_byte2;
  wire [7:0] fin_b2 = second_ok ? mem_rd_data : byte2;
  wire fin_drive_frequency_code = (stage == 2'h2);
  wire [8:0] fin_code = {byte2[DRIVE_FREQUENCY_CODE_MSB_BIT], mem_rd_data};

  // timebase multiplier in units of the shortest timebase
  logic [6:0] tb_mult;
  always_comb begin
    case ({fast_timebase_sel, fin_b1[TB_MSB:TB_LSB]})
      3'h0: tb_mult = TB_MULT_4; // see (RULE3)
      3'h1: tb_mult = TB_MULT_16;
      3'h2: tb_mult = TB_MULT_32;
      3'h3: tb_mult = TB_MULT_64;
      3'h4: tb_mult = TB_MULT_1; // see (RULE4)
      3'h5: tb_mult = TB_MULT_4;
      3'h6: tb_mult = TB_MULT_16;
      3'h7: tb_mult = TB_MULT_32;
      default: tb_mult = TB_MULT_4;
    endcase
  end
  wire [21:0] tb_len = 22'(TB_CYCLES) * {15'h0000, tb_mult};

  // ==========================================================
  // frequency decode
  wire [10:0] drive_frequency_code_raw_hz = {1'b0, fin_code, 1'b0} + DRIVE_FREQUENCY_CODE_STEP_OFFSET_HZ; // see (RULE10)
  wire [10:0] drive_frequency_code_hz = (drive_frequency_code_raw_hz < DRIVE_FREQUENCY_CODE_MIN_HZ) ? DRIVE_FREQUENCY_CODE_MIN_HZ : drive_frequency_code_raw_hz; // see (RULE11)
  wire drive_frequency_code_load = commit_now && fin_drive_frequency_code;

  hfd_period_div u_div (
    .clk(ref_clk),
    .rst_n(rst_sync_n),
    .start(drive_frequency_code_load),
    .drive_frequency_code_hz(drive_frequency_code_hz),
    .busy(period_busy),
    .done(),
    .period(active_period_readback)
  );

  // ==========================================================
  // sequencing
  wire pass_take = (state == HFD_PASS) && pass_ready;
  wire passes_over = (pass_number == repeat_count);
  logic seq_ended;

  always_comb begin
    next_state = state;
    case (state)
      HFD_IDLE: begin
        if (seq_start) begin
          next_state = HFD_READ;
        end
      end
      HFD_READ: begin
        next_state = HFD_WAIT;
      end
      HFD_WAIT: begin
        if (mem_rd_valid) begin
          if (commit_now) begin
            next_state = HFD_PASS;
          end else if (at_last && consume) begin
            next_state = HFD_IDLE;
          end else begin
            next_state = HFD_READ;
          end
        end
      end
      HFD_PASS: begin
        if (pass_take && passes_over) begin
          next_state = seq_ended ? HFD_IDLE : HFD_READ;
        end
      end
      default: next_state = HFD_IDLE;
    endcase
  end

  assign mem_rd_en = (state == HFD_READ);
  assign pass_valid = (state == HFD_PASS);
  assign seq_busy = (state != HFD_IDLE);

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= HFD_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // byte collection and address walk
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stage <= 2'h0;
      byte1 <= 8'h00;
      byte2 <= 8'h00;
      have_byte2 <= 1'b0;
      mem_addr <= '0;
      seq_ended <= 1'b0;
    end else if (state == HFD_IDLE && seq_start) begin
      stage <= 2'h0;
      have_byte2 <= 1'b0;
      mem_addr <= seq_first_addr;
      seq_ended <= 1'b0;
    end else if (state == HFD_WAIT && mem_rd_valid) begin
      if (consume && !at_last) begin
        mem_addr <= mem_addr + 1'b1;
      end
      seq_ended <= consume && at_last;
      if (commit_now) begin
        // a first byte that closed the frame is fetched again as a fresh frame start
        stage <= 2'h0;
        have_byte2 <= 1'b0;
      end else if (stage == 2'h0) begin
        if (!first_bad) begin
          byte1 <= mem_rd_data;
          stage <= 2'h1;
        end
      end else if (second_ok) begin
        byte2 <= mem_rd_data;
        have_byte2 <= 1'b1;
        stage <= 2'h2;
      end
    end
  end

  // ==========================================================
  // pass command registers
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      snippet_index <= 4'h0;
      silent_snippet <= 1'b0;
      silent_timebases <= 3'h0;
      gain_code <= 2'h0;
      atten_db <= 5'h00;
      timebase_code <= 2'h0;
      timebase_cycles <= 22'h000000;
      repeat_count <= 4'h0;
      pass_number <= 4'h0;
      restart_from_first <= 1'b0;
      last_pass <= 1'b0;
    end else if (commit_now) begin
      snippet_index <= {fin_has2 ? fin_b2[IDX_HIGH_BIT] : 1'b0,
                        fin_b1[IDX_LOW_MSB:0]}; // see (RULE5) (RULE13)
      silent_snippet <= !(fin_has2 && fin_b2[IDX_HIGH_BIT]) &&
                        (fin_b1[IDX_LOW_MSB:0] == 3'h0); // see (RULE17)
      silent_timebases <= SILENT_TIMEBASES; // see (RULE17)
      gain_code <= fin_b1[GAIN_MSB:GAIN_LSB];
      atten_db <= 5'(fin_b1[GAIN_MSB:GAIN_LSB] * ATTEN_STEP_DB); // see (RULE2)
      timebase_code <= fin_b1[TB_MSB:TB_LSB];
      timebase_cycles <= tb_len; // see (RULE3) (RULE4)
      repeat_count <= fin_has2 ? fin_b2[REP_MSB:REP_LSB] : 4'h0; // see (RULE6) (RULE7)
      pass_number <= 4'h0;
      restart_from_first <= 1'b0;
      last_pass <= !(fin_has2 && fin_b2[REP_MSB:REP_LSB] != 4'h0);
    end else if (pass_take && !passes_over) begin
      pass_number <= pass_number + 4'h1;
      restart_from_first <= 1'b1; // see (RULE8)
      last_pass <= (pass_number + 4'h1 == repeat_count);
    end
  end

  // ==========================================================
  // events and held frequency
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mem_fault <= 1'b0;
      seq_done <= 1'b0;
      drive_frequency_code_update <= 1'b0;
      drive_frequency_code <= DRIVE_FREQUENCY_CODE_CODE_RESET;
      drive_frequency_code_commanded <= 1'b0;
    end else begin
      mem_fault <= (state == HFD_WAIT) && mem_rd_valid && first_bad; // see (RULE16)
      seq_done <= ((state == HFD_PASS) && pass_take && passes_over && seq_ended) ||
                  ((state == HFD_WAIT) && mem_rd_valid && !commit_now && at_last && consume);
      drive_frequency_code_update <= drive_frequency_code_load;
      if (drive_frequency_code_load) begin
        drive_frequency_code <= fin_code; // see (RULE14)
        drive_frequency_code_commanded <= 1'b1;
      end
    end
  end

  // commanded frequency stays in force only while tracking is off
  assign drive_frequency_code_hold = drive_frequency_code_commanded && !resonance_tracking_enable; // see (RULE14) (RULE15)

endmodule
`default_nettype wire

// File: hfd_mem_model.sv
// waveform memory model answering reads after a short or long delay
`timescale 1ns/10ps
`default_nettype none
module hfd_mem_model (
  input wire logic ref_clk,
  input wire logic mem_rd_en,
  input wire logic [6:0] mem_addr,
  input wire logic slow,
  output logic mem_rd_valid,
  output logic [7:0] mem_rd_data
);
  logic [7:0] mem [0:127];
  logic [7:0] last = 8'h00;
  logic [6:0] a = 7'h00;
  int n = 0;
  initial mem_rd_valid = 1'b0;
  initial mem_rd_data = 8'h00;
  // one read at a time; idle data shows the inverse of the last byte
  always @(posedge ref_clk) begin
    mem_rd_valid <= 1'b0;
    mem_rd_data <= ~last;
    if (mem_rd_en) begin
      a <= mem_addr;
      n <= slow ? 5 : 1;
    end else if (n == 1) begin
      mem_rd_valid <= 1'b1;
      mem_rd_data <= mem[a];
      last <= mem[a];
      n <= 0;
    end else if (n > 1) begin
      n <= n - 1;
    end
  end
endmodule
`default_nettype wire

// File: hfd_assertions.sv
// port checker for the frame decoder
`timescale 1ns/10ps
`default_nettype none
module hfd_chk
  import hfd_pkg::*;
#(
  parameter int ADDR_W = 7,
  parameter int TB_CYCLES = 4
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic mem_fault,
  input wire logic mem_rd_valid,
  input wire logic [7:0] mem_rd_data,
  input wire logic pass_valid,
  input wire logic pass_ready,
  input wire logic [3:0] snippet_index,
  input wire logic silent_snippet,
  input wire logic [2:0] silent_timebases,
  input wire logic [1:0] gain_code,
  input wire logic [4:0] atten_db,
  input wire logic fast_timebase_sel,
  input wire logic [1:0] timebase_code,
  input wire logic [21:0] timebase_cycles,
  input wire logic [3:0] repeat_count,
  input wire logic [3:0] pass_number,
  input wire logic restart_from_first,
  input wire logic last_pass,
  input wire logic [8:0] drive_frequency_code,
  input wire logic drive_frequency_code_commanded,
  input wire logic drive_frequency_code_hold,
  input wire logic resonance_tracking_enable,
  input wire logic period_busy,
  input wire logic [15:0] active_period_readback
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  function automatic logic [21:0] tb_len(logic f, logic [1:0] c);
    int m [4] = '{4, 16, 32, 64};
    return 22'(TB_CYCLES * (f ? ((c == 2'h0) ? 1 : m[c - 1]) : m[c]));
  endfunction
  function automatic logic [15:0] per(logic [8:0] c);
    int hz;
    hz = 2 * c + 2;
    return 16'(1000000 / ((hz < 25) ? 25 : hz));
  endfunction
  sequence s_take;
    pass_valid && pass_ready && !last_pass;
  endsequence
  sequence s_div_end;
    $fell(period_busy);
  endsequence
  // ==========================================================
  // assertions
  chk_fault_type: assert property (
    mem_fault |-> $past(mem_rd_valid) && $past(mem_rd_data[7]))
    else $error("fault without a flagged first byte");
  chk_atten_map: assert property (
    pass_valid |-> atten_db == 5'(6 * gain_code))
    else $error("attenuation does not match gain code");
  chk_timebase_map: assert property (
    pass_valid |-> timebase_cycles == tb_len(fast_timebase_sel, timebase_code))
    else $error("timebase length wrong");
  chk_silent_index: assert property (
    pass_valid |-> silent_snippet == (snippet_index == 4'h0) && silent_timebases == 3'h2)
    else $error("silent snippet decode wrong");
  chk_restart_flag: assert property (
    pass_valid |-> restart_from_first == (pass_number != 4'h0))
    else $error("restart flag wrong");
  chk_last_pass: assert property (
    pass_valid |-> last_pass == (pass_number == repeat_count))
    else $error("last pass flag wrong");
  chk_pass_advance: assert property (
    s_take |=> pass_valid && pass_number == $past(pass_number) + 4'h1)
    else $error("pass number did not advance");
  chk_drive_frequency_code_hold: assert property (
    drive_frequency_code_hold == (drive_frequency_code_commanded && !resonance_tracking_enable))
    else $error("frequency hold wrong");
  chk_period_value: assert property (
    s_div_end |=> active_period_readback == per(drive_frequency_code))
    else $error("period readback wrong");
endmodule
bind hfd_frame_decoder hfd_chk #(.ADDR_W(ADDR_W), .TB_CYCLES(TB_CYCLES)) hfd_chk_i (
  .ref_clk, .rst_n, .mem_fault, .mem_rd_valid, .mem_rd_data, .pass_valid, .pass_ready,
  .snippet_index, .silent_snippet, .silent_timebases, .gain_code, .atten_db,
  .fast_timebase_sel, .timebase_code, .timebase_cycles, .repeat_count, .pass_number,
  .restart_from_first, .last_pass, .drive_frequency_code, .drive_frequency_code_commanded, .drive_frequency_code_hold,
  .resonance_tracking_enable, .period_busy, .active_period_readback);
`default_nettype wire

// File: testbench.sv
// self-checking bench for the frame decoder
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int TBC = 4;
  logic ref_clk = 0, rst_n = 0, seq_start = 0, fast_timebase_sel = 0, pass_ready = 0;
  logic resonance_tracking_enable = 0, slow = 0, mem_rd_en, mem_rd_valid, seq_busy, seq_done;
  logic [6:0] seq_first_addr = 0, seq_last_addr = 0, mem_addr;
  logic [7:0] mem_rd_data;
  logic mem_fault, pass_valid, silent_snippet, restart_from_first, last_pass, drive_frequency_code_commanded;
  logic drive_frequency_code_hold, drive_frequency_code_update, period_busy;
  logic [3:0] snippet_index, repeat_count, pass_number;
  logic [2:0] silent_timebases;
  logic [1:0] gain_code, timebase_code;
  logic [4:0] atten_db;
  logic [21:0] timebase_cycles;
  logic [8:0] drive_frequency_code;
  logic [15:0] active_period_readback;
  int mismatches = 0, n_compared = 0, n_fault = 0, n_upd = 0;
  int mult [4] = '{4, 16, 32, 64};
  hfd_frame_decoder #(.TB_CYCLES(TBC)) hfd_frame_decoder_i (.ref_clk, .rst_n, .seq_start,
    .seq_first_addr, .seq_last_addr, .fast_timebase_sel, .resonance_tracking_enable,
    .seq_busy, .seq_done, .mem_fault, .mem_rd_en, .mem_addr, .mem_rd_valid, .mem_rd_data,
    .pass_valid, .pass_ready, .snippet_index, .silent_snippet, .silent_timebases, .gain_code,
    .atten_db, .timebase_code, .timebase_cycles, .repeat_count, .pass_number,
    .restart_from_first, .last_pass, .drive_frequency_code, .drive_frequency_code_commanded, .drive_frequency_code_hold,
    .drive_frequency_code_update, .active_period_readback, .period_busy);
  hfd_mem_model hfd_mem_model_i (.ref_clk, .mem_rd_en, .mem_addr, .slow, .mem_rd_valid,
    .mem_rd_data);
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (mem_fault === 1'b1) n_fault++;
  always @(posedge ref_clk) if (drive_frequency_code_update === 1'b1) n_upd++;
  // ==========================================================
  // shared tasks
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic run_seq(int f, int l);
    @(negedge ref_clk);
    seq_first_addr = 7'(f);
    seq_last_addr = 7'(l);
    seq_start = 1'b1;
    @(negedge ref_clk);
    seq_start = 1'b0;
  endtask
  task automatic take(int idx, int at, int tb, int rep, int pn);
    int k = 0;
    while (pass_valid !== 1'b1 && k < 200) begin
      @(negedge ref_clk);
      k++;
    end
    check("valid", pass_valid, 1);
    check("index", snippet_index, idx);
    check("silent", silent_snippet, idx == 0);
    check("atten", atten_db, at);
    check("tbase", timebase_cycles, tb);
    check("repeat", repeat_count, rep);
    check("pass", pass_number, pn);
    check("restart", restart_from_first, pn != 0);
    check("last", last_pass, pn == rep);
    pass_ready = 1'b1;
    @(negedge ref_clk);
    pass_ready = 1'b0;
  endtask
  task automatic wait_done;
    int k = 0;
    while (seq_done !== 1'b1 && k < 200) begin
      @(negedge ref_clk);
      k++;
    end
    check("done", seq_done, 1);
    check("idle", seq_busy, 0);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_plain(logic f);
    for (int i = 0; i < 4; i++) hfd_mem_model_i.mem[i] = 8'(i * 40 + i + 4);
    fast_timebase_sel = f;
    run_seq(0, 3);
    for (int i = 0; i < 4; i++) take(i + 4, 6 * i, TBC * (f ? (i ? mult[i - 1] : 1) : mult[i]), 0, 0);
    wait_done;
  endtask
  task automatic t_loop;
    int nf;
    nf = n_fault;
    hfd_mem_model_i.mem[10] = 8'h63;
    hfd_mem_model_i.mem[11] = 8'h91;
    hfd_mem_model_i.mem[12] = 8'h80;
    hfd_mem_model_i.mem[13] = 8'h01;
    fast_timebase_sel = 1'b0;
    slow = 1'b1;
    run_seq(10, 13);
    for (int p = 0; p < 3; p++) take(11, 18, TBC * 4, 2, p);
    take(1, 0, TBC * 4, 0, 0);
    wait_done;
    check("faults", n_fault - nf, 1);
    slow = 1'b0;
  endtask
  task automatic t_drive_frequency_code;
    logic [7:0] b2 [3] = '{8'h84, 8'h86, 8'h84};
    logic [7:0] b3 [3] = '{8'h05, 8'hff, 8'h0c};
    int pr [3] = '{40000, 976, 38461};
    resonance_tracking_enable = 1'b0;
    for (int i = 0; i < 3; i++) begin
      hfd_mem_model_i.mem[20] = 8'h58;
      hfd_mem_model_i.mem[21] = b2[i];
      hfd_mem_model_i.mem[22] = b3[i];
      run_seq(20, 22);
      take(0, 12, TBC * 64, 0, 0);
      wait_done;
      repeat (30) @(negedge ref_clk);
      check("code", drive_frequency_code, {b2[i][1], b3[i]});
      check("period", active_period_readback, pr[i]);
      check("hold", drive_frequency_code_hold, 1);
    end
    check("updates", n_upd, 3);
    check("cmd", drive_frequency_code_commanded, 1);
    run_seq(13, 13);
    take(1, 0, TBC * 4, 0, 0);
    wait_done;
    check("kept", drive_frequency_code, 9'h00c);
    resonance_tracking_enable = 1'b1;
    #1 check("tracked", drive_frequency_code_hold, 0);
    resonance_tracking_enable = 1'b0;
  endtask
  initial begin
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    t_plain(1'b0);
    t_plain(1'b1);
    t_loop;
    t_drive_frequency_code;
    results;
  end
  initial begin
    #400000;
    mismatches++;
    results;
  end
endmodule
`default_nettype wire
